// ==== line_modem_pkg.sv ====
package line_modem_pkg;
	// clock and timing figures, times in their own unit
	localparam int unsigned CLK_PERIOD_NS   = 100;
	localparam int unsigned DIR_TIMEOUT_NS  = 1_000_000_000; // 1 s
	localparam int unsigned WD_TIMEOUT_NS   = 1_500_000_000; // 1.5 s
	localparam int unsigned BAUD_RATE       = 1200;
	localparam int unsigned DIR_TIMEOUT_CYC = DIR_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int unsigned WD_TIMEOUT_CYC  = WD_TIMEOUT_NS / CLK_PERIOD_NS;
	// bit time rounded down, still above the 833 us minimum
	localparam int unsigned BIT_CYC = 1_000_000_000 / (CLK_PERIOD_NS * BAUD_RATE);

	// character layout: start, eight data, odd parity, stop
	localparam int unsigned DATA_BITS  = 8;
	localparam logic [3:0]  FRAME_BITS = 4'hB;
	localparam logic [3:0]  RX_BITS    = 4'hA;

	// synchronised pin positions
	localparam int unsigned PIN_DIR    = 0;
	localparam int unsigned PIN_WD     = 1;
	localparam int unsigned PIN_TXD    = 2;
	localparam int unsigned PIN_SUPPLY = 3;
	localparam int unsigned NUM_PINS   = 4;

	// reset values
	localparam logic [3:0] PIN_RST     = 4'h7;
	localparam logic       TX_MODE_RST = 1'h0;
	localparam logic       CD_N_RST    = 1'h1;
	localparam logic       RST_OUT_RST = 1'h0;
	localparam logic       LINE_IDLE   = 1'h1;

	// character handed to the modulator
	typedef struct packed {
		logic [DATA_BITS-1:0] data;
		logic                 parity_err;
		logic                 frame_err;
	} host_char_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10
	} host_rx_state_t;

	typedef enum logic {
		TX_IDLE  = 1'b0,
		TX_SHIFT = 1'b1
	} host_tx_state_t;
endpackage

// ==== line_modem_ctrl.sv ====
`timescale 1ns/1ps
// Overview of operation
// - direction low selects transmit, else receive
// - direction low over 1s forces receive
// - carrier present drives carrier_detect_n low
// - reset output high: low supply, watchdog silent
// - modem returns received data on serial_in_pin
// - character: start, eight data, odd parity, stop
module line_modem_ctrl
	import line_modem_pkg::*;
#(
	parameter int unsigned DIR_CYC = DIR_TIMEOUT_CYC, // transmit hold limit
	parameter int unsigned WD_CYC  = WD_TIMEOUT_CYC,  // watchdog silence limit
	parameter int unsigned BIT_T   = BIT_CYC          // cycles per serial bit
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	input  wire logic                 rx_tx_select,
	input  wire logic                 watchdog_strobe,
	input  wire logic                 serial_out_pin,
	input  wire logic                 supply_low,
	input  wire logic                 carrier_present,
	input  wire logic [DATA_BITS-1:0] rx_byte,
	input  wire logic                 rx_byte_valid,
	output wire logic                 rx_byte_ready,
	output wire logic                 serial_in_pin,
	output wire logic                 carrier_detect_n,
	output wire logic                 modem_reset_output,
	output wire logic                 tx_mode,
	output host_char_t                tx_char,
	output wire logic                 tx_char_valid
);
	localparam int unsigned HALF_T = BIT_T / 2; // start bit centre

	// odd parity bit for a data byte
	function automatic logic odd_parity(input logic [DATA_BITS-1:0] d);
		odd_parity = ~^d;
	endfunction

	// pin synchronisers and filtered levels
	logic [NUM_PINS-1:0] meta_ff;   // first stage, read only by mid_ff
	logic [NUM_PINS-1:0] mid_ff;    // second stage
	logic [NUM_PINS-1:0] late_ff;   // third stage
	logic [NUM_PINS-1:0] pin_f_ff;  // level once stages two and three agree
	wire  [NUM_PINS-1:0] pins_raw = {supply_low, serial_out_pin, watchdog_strobe, rx_tx_select};

	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_sync
			// a change counts only after two stages agree, rejecting glitches
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_ff[g]  <= PIN_RST[g];
					mid_ff[g]   <= PIN_RST[g];
					late_ff[g]  <= PIN_RST[g];
					pin_f_ff[g] <= PIN_RST[g];
				end else begin
					meta_ff[g] <= pins_raw[g];
					mid_ff[g]  <= meta_ff[g];
					late_ff[g] <= mid_ff[g];
					if (mid_ff[g] == late_ff[g]) begin
						pin_f_ff[g] <= late_ff[g];
					end
				end
			end
		end
	endgenerate

	// direction select and transmit timeout
	logic [31:0] dir_cnt_ff;  // cycles spent with direction low
	logic        tx_mode_ff;  // modem in transmit
	wire         dir_tx_req  = ~pin_f_ff[PIN_DIR];
	wire         dir_expired = (dir_cnt_ff >= DIR_CYC);
	wire         nxt_tx_mode = dir_tx_req & ~dir_expired;

	// counter saturates so a stuck-low line stays in receive until released
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_cnt_ff <= 32'h0000_0000;
			tx_mode_ff <= TX_MODE_RST;
		end else begin
			if (!dir_tx_req) begin
				dir_cnt_ff <= 32'h0000_0000;
			end else if (!dir_expired) begin
				dir_cnt_ff <= dir_cnt_ff + 32'h0000_0001;
			end
			tx_mode_ff <= nxt_tx_mode;
		end
	end

	// watchdog and reset output
	logic [31:0] wd_cnt_ff;     // cycles since last falling strobe
	logic        wd_prev_ff;    // strobe level one cycle back
	logic        rst_out_ff;    // reset output to host
	wire         wd_fall     = wd_prev_ff & ~pin_f_ff[PIN_WD];
	wire         wd_expired  = (wd_cnt_ff >= WD_CYC);
	wire         nxt_rst_out = pin_f_ff[PIN_SUPPLY] | wd_expired;

	// only falling transitions feed the watchdog, a held level does not
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wd_cnt_ff  <= 32'h0000_0000;
			wd_prev_ff <= PIN_RST[PIN_WD];
			rst_out_ff <= RST_OUT_RST;
		end else begin
			wd_prev_ff <= pin_f_ff[PIN_WD];
			if (wd_fall) begin
				wd_cnt_ff <= 32'h0000_0000;
			end else if (!wd_expired) begin
				wd_cnt_ff <= wd_cnt_ff + 32'h0000_0001;
			end
			rst_out_ff <= nxt_rst_out;
		end
	end

	// carrier detect, active low
	logic cd_n_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cd_n_ff <= CD_N_RST;
		end else begin
			cd_n_ff <= ~carrier_present;
		end
	end

	// two-entry buffer between demodulator and host serial line
	logic [DATA_BITS-1:0] buf_mem [2]; // stored received bytes
	logic                 wr_ptr_ff;
	logic                 rd_ptr_ff;
	logic [1:0]           buf_cnt_ff;
	logic                 buf_ready_ff; // registered so ready is a clean flop
	host_tx_state_t       tx_state_ff;
	wire                  buf_push    = rx_byte_valid & buf_ready_ff;
	wire                  buf_pop     = (tx_state_ff == TX_IDLE) & (buf_cnt_ff != 2'h0);
	wire  [1:0]           nxt_buf_cnt = buf_cnt_ff + {1'b0, buf_push} - {1'b0, buf_pop};
	wire  [DATA_BITS-1:0] buf_head    = buf_mem[rd_ptr_ff];

	// storage needs no reset, occupancy does
	always_ff @(posedge core_clk) begin
		if (buf_push) begin
			buf_mem[wr_ptr_ff] <= rx_byte;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_ff    <= 1'h0;
			rd_ptr_ff    <= 1'h0;
			buf_cnt_ff   <= 2'h0;
			buf_ready_ff <= 1'h1;
		end else begin
			wr_ptr_ff    <= wr_ptr_ff ^ buf_push;
			rd_ptr_ff    <= rd_ptr_ff ^ buf_pop;
			buf_cnt_ff   <= nxt_buf_cnt;
			buf_ready_ff <= (nxt_buf_cnt != 2'h2);
		end
	end

	// serial transmitter toward the host receive pin
	logic [10:0] tx_shift_ff;  // frame, lsb leaves first
	logic [3:0]  tx_bit_ff;    // bits already sent
	logic [31:0] tx_baud_ff;   // cycles into current bit
	logic        serial_ff;    // line level
	wire [10:0]  tx_frame = {1'b1, odd_parity(buf_head), buf_head, 1'b0};
	wire         tx_bit_end = (tx_baud_ff == BIT_T - 1);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_ff <= TX_IDLE;
			tx_shift_ff <= 11'h7FF;
			tx_bit_ff   <= 4'h0;
			tx_baud_ff  <= 32'h0000_0000;
			serial_ff   <= LINE_IDLE;
		end else begin
			case (tx_state_ff)
				TX_IDLE: begin
					if (buf_pop) begin
						tx_shift_ff <= tx_frame;
						tx_bit_ff   <= 4'h0;
						tx_baud_ff  <= 32'h0000_0000;
						serial_ff   <= 1'b0;
						tx_state_ff <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					if (!tx_bit_end) begin
						tx_baud_ff <= tx_baud_ff + 32'h0000_0001;
					end else if (tx_bit_ff == FRAME_BITS - 4'h1) begin
						// stop bit done, line rests high
						serial_ff   <= LINE_IDLE;
						tx_state_ff <= TX_IDLE;
					end else begin
						tx_baud_ff  <= 32'h0000_0000;
						tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
						tx_bit_ff   <= tx_bit_ff + 4'h1;
						serial_ff   <= tx_shift_ff[1];
					end
				end
				default: begin
					tx_state_ff <= TX_IDLE;
				end
			endcase
		end
	end

	// serial receiver from the host transmit pin
	host_rx_state_t rx_state_ff;
	logic [9:0]     rx_shift_ff;   // data, parity, stop as they arrive
	logic [3:0]     rx_bit_ff;     // bits sampled after start
	logic [31:0]    rx_baud_ff;    // cycles into current bit
	logic           txd_prev_ff;   // host line one cycle back
	host_char_t     char_ff;
	logic           char_valid_ff;
	wire            txd         = pin_f_ff[PIN_TXD];
	wire            rx_fall     = txd_prev_ff & ~txd;
	wire            rx_mid_end  = (rx_baud_ff == HALF_T - 1);
	wire            rx_bit_end  = (rx_baud_ff == BIT_T - 1);
	wire [9:0]      rx_nxt_sh   = {txd, rx_shift_ff[9:1]};
	wire            rx_done     = (rx_state_ff == RX_DATA) & rx_bit_end &
	                              (rx_bit_ff == RX_BITS - 4'h1);

	// start bit rechecked at its centre, so a short glitch is dropped
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_ff   <= RX_IDLE;
			rx_shift_ff   <= 10'h000;
			rx_bit_ff     <= 4'h0;
			rx_baud_ff    <= 32'h0000_0000;
			txd_prev_ff   <= LINE_IDLE;
			char_ff       <= '0;
			char_valid_ff <= 1'h0;
		end else begin
			txd_prev_ff   <= txd;
			char_valid_ff <= rx_done;
			case (rx_state_ff)
				RX_IDLE: begin
					rx_baud_ff <= 32'h0000_0000;
					if (rx_fall) begin
						rx_state_ff <= RX_START;
					end
				end
				RX_START: begin
					if (!rx_mid_end) begin
						rx_baud_ff <= rx_baud_ff + 32'h0000_0001;
					end else begin
						rx_baud_ff  <= 32'h0000_0000;
						rx_bit_ff   <= 4'h0;
						rx_state_ff <= txd ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (!rx_bit_end) begin
						rx_baud_ff <= rx_baud_ff + 32'h0000_0001;
					end else begin
						rx_baud_ff  <= 32'h0000_0000;
						rx_shift_ff <= rx_nxt_sh;
						rx_bit_ff   <= rx_bit_ff + 4'h1;
						if (rx_done) begin
							char_ff.data       <= rx_nxt_sh[7:0];
							char_ff.parity_err <= odd_parity(rx_nxt_sh[7:0]) != rx_nxt_sh[8];
							char_ff.frame_err  <= ~rx_nxt_sh[9];
							rx_state_ff        <= RX_IDLE;
						end
					end
				end
				default: begin
					rx_state_ff <= RX_IDLE;
				end
			endcase
		end
	end

	// outputs straight from flops
	assign rx_byte_ready      = buf_ready_ff;
	assign serial_in_pin      = serial_ff;
	assign carrier_detect_n   = cd_n_ff;
	assign modem_reset_output = rst_out_ff;
	assign tx_mode            = tx_mode_ff;
	assign tx_char            = char_ff;
	assign tx_char_valid      = char_valid_ff;

	// checks
	sequence seq_char_load;
		buf_pop;
	endsequence
	sequence seq_start_bit;
		(!serial_ff)[*8];
	endsequence

	AST_TX_ONLY_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
		tx_mode_ff |-> $past(dir_tx_req)) else $error("transmit without direction low");
	AST_RX_WHEN_HIGH: assert property (@(posedge core_clk) disable iff (!rst_n)
		!dir_tx_req |=> !tx_mode_ff) else $error("direction high left transmit on");
	AST_DIR_TIMEOUT: assert property (@(posedge core_clk) disable iff (!rst_n)
		(dir_cnt_ff == DIR_CYC) |=> !tx_mode_ff) else $error("transmit timeout ignored");
	AST_CD_FOLLOWS: assert property (@(posedge core_clk) disable iff (!rst_n)
		carrier_present |=> !cd_n_ff) else $error("carrier seen but detect high");
	AST_WD_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wd_cnt_ff == WD_CYC) |=> rst_out_ff) else $error("watchdog expiry without reset");
	AST_SUPPLY_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
		pin_f_ff[PIN_SUPPLY] |=> rst_out_ff) else $error("low supply without reset");
	AST_NO_SPURIOUS_RESET: assert property (@(posedge core_clk) disable iff (!rst_n)
		rst_out_ff |-> ($past(pin_f_ff[PIN_SUPPLY]) || ($past(wd_cnt_ff) >= WD_CYC)))
		else $error("reset output without cause");
	AST_START_BIT: assert property (@(posedge core_clk) disable iff (!rst_n)
		seq_char_load |=> seq_start_bit) else $error("start bit too short");
	AST_ODD_PARITY: assert property (@(posedge core_clk) disable iff (!rst_n)
		seq_char_load |=> (^tx_shift_ff[9:1]) && tx_shift_ff[10]) else $error("bad frame");
	AST_BUF_BOUND: assert property (@(posedge core_clk) disable iff (!rst_n)
		(buf_cnt_ff == 2'h2) |-> !buf_ready_ff && (wr_ptr_ff == rd_ptr_ff))
		else $error("buffer full but ready or pointers apart");
endmodule

// ==== host_model.sv ====
`timescale 1ns/1ps
// host side of the modem pins, with its two interrupt inputs
module host_model #(
	parameter int unsigned BIT_T = 16 // cycles per serial bit
) (
	input  wire logic core_clk, // host runs on the modem master clock
	input  wire logic serial_in_pin,
	input  wire logic carrier_detect_n,
	input  wire logic modem_reset_output,
	output logic      watchdog_strobe,
	output logic      serial_out_pin,
	output logic      rx_tx_select
);
	int cd_irqs  = 0; // carrier interrupts taken
	int nmi_irqs = 0; // non-maskable interrupts taken

	// pins start released: strobe high, line idle, receive mode
	initial begin
		watchdog_strobe = 1'b1;
		serial_out_pin  = 1'b1;
		rx_tx_select    = 1'b1;
	end

	// edge-triggered interrupt inputs
	always @(negedge carrier_detect_n) cd_irqs++;
	always @(posedge modem_reset_output) nmi_irqs++;

	// host restart line, low while the modem reset output holds it
	wire  host_rst_n = ~modem_reset_output;

	// command keys rest low, pressed high; one per slave plus room
	logic [2:0] cmd_keys    = 3'h0;
	logic [2:0] status_leds = 3'h0; // matching status outputs

	// heartbeat blinks every cycle while the main loop runs
	logic heartbeat = 1'b0;
	always @(posedge core_clk) heartbeat <= ~heartbeat;

	// low pulse of eight cycles, well over the minimum width
	task automatic wd_kick();
		@(negedge core_clk) watchdog_strobe = 1'b0;
		repeat (8) @(negedge core_clk);
		watchdog_strobe = 1'b1;
	endtask

	// direction line, low means transmit
	task automatic set_dir(input logic v);
		@(negedge core_clk) rx_tx_select = v;
	endtask

	// start, data lsb first, odd parity, stop; errors only on request
	task automatic send_char(input logic [7:0] d, input logic bad_par, input logic bad_stop);
		logic [10:0] f;
		f = {~bad_stop, (~^d) ^ bad_par, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(negedge core_clk) serial_out_pin = f[i];
			repeat (BIT_T - 1) @(negedge core_clk);
		end
		@(negedge core_clk) serial_out_pin = 1'b1;
	endtask

	// sample one character mid-bit; returns data, parity, stop
	task automatic recv_char(output logic [9:0] got);
		int n;
		n = 0;
		while (serial_in_pin !== 1'b0 && n < 4000) begin
			@(negedge core_clk);
			n++;
		end
		repeat (BIT_T / 2) @(negedge core_clk);
		for (int i = 0; i < 10; i++) begin
			repeat (BIT_T) @(negedge core_clk);
			got[i] = serial_in_pin;
		end
	endtask
endmodule

// ==== line_modem_ctrl_test.sv ====
`timescale 1ns/1ps
module line_modem_ctrl_test;
	import line_modem_pkg::*;
	localparam int unsigned DIR_T = 200; // shortened transmit hold limit
	localparam int unsigned WD_T  = 300; // shortened watchdog limit
	localparam int unsigned BT    = 16;  // shortened bit time
	logic       core_clk, rst_n, supply_low, carrier_present, rx_byte_valid;
	logic [7:0] rx_byte;
	wire logic  rx_tx_select, watchdog_strobe, serial_out_pin, rx_byte_ready;
	wire logic  serial_in_pin, carrier_detect_n, modem_reset_output, tx_mode, tx_char_valid;
	host_char_t tx_char;
	int         n_errors  = 0;
	int         tests_run = 0;
	int         stalls    = 0; // cycles the buffer refused a byte
	int         n0;
	logic [9:0] got;
	logic       hb0; // heartbeat level one cycle back
	logic [7:0] bytes [4] = '{8'h00, 8'hFF, 8'hA5, 8'h3C};

	line_modem_ctrl #(.DIR_CYC(DIR_T), .WD_CYC(WD_T), .BIT_T(BT)) line_modem_ctrl_i (
		.core_clk(core_clk), .rst_n(rst_n), .rx_tx_select(rx_tx_select),
		.watchdog_strobe(watchdog_strobe), .serial_out_pin(serial_out_pin),
		.supply_low(supply_low), .carrier_present(carrier_present), .rx_byte(rx_byte),
		.rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready),
		.serial_in_pin(serial_in_pin), .carrier_detect_n(carrier_detect_n),
		.modem_reset_output(modem_reset_output), .tx_mode(tx_mode), .tx_char(tx_char),
		.tx_char_valid(tx_char_valid));
	host_model #(.BIT_T(BT)) host_model_i (
		.core_clk(core_clk), .serial_in_pin(serial_in_pin),
		.carrier_detect_n(carrier_detect_n), .modem_reset_output(modem_reset_output),
		.watchdog_strobe(watchdog_strobe), .serial_out_pin(serial_out_pin),
		.rx_tx_select(rx_tx_select));

	// 10 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// compare and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		if (n_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// host sends a character while the decoded one is awaited
	task automatic host_send(input logic [7:0] d, input logic pe, input logic fe);
		int n;
		n = 0;
		fork
			host_model_i.send_char(d, pe, fe);
			begin
				// pulse lasts one cycle, so poll every cycle, bounded
				while (tx_char_valid !== 1'b1 && n < 400) begin
					@(negedge core_clk);
					n++;
				end
				check("tx_char", tx_char, {d, pe, fe});
			end
		join
	endtask

	// offer a byte and hold it until taken; valid stays up for the next
	task automatic push(input logic [7:0] d);
		int n;
		n = 0;
		rx_byte       = d;
		rx_byte_valid = 1'b1;
		while (rx_byte_ready !== 1'b1 && n < 400) begin
			@(negedge core_clk);
			stalls++;
			n++;
		end
		@(negedge core_clk);
	endtask

	// hang guard, far above the few thousand cycles expected
	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		tally_and_finish();
	end

	initial begin
		rst_n           = 1'b0;
		supply_low      = 1'b0;
		carrier_present = 1'b0;
		rx_byte         = 8'h00;
		rx_byte_valid   = 1'b0;
		repeat (20) @(negedge core_clk);
		check("reset outs", {rx_byte_ready, serial_in_pin, carrier_detect_n,
			modem_reset_output, tx_mode, tx_char_valid, tx_char}, 16'hE000);
		rst_n = 1'b1;
		// carrier detect follows one cycle late, active low
		n0              = host_model_i.cd_irqs;
		carrier_present = 1'b1;
		@(negedge core_clk);
		check("carrier_detect_n", carrier_detect_n, 16'h0000);
		check("cd irqs", 16'(host_model_i.cd_irqs - n0), 16'h0001);
		carrier_present = 1'b0;
		@(negedge core_clk);
		check("carrier_detect_n", carrier_detect_n, 16'h0001);
		// direction: transmit, then forced back after the hold limit
		host_model_i.set_dir(1'b0);
		repeat (10) @(negedge core_clk);
		check("tx_mode", tx_mode, 16'h0001);
		repeat (DIR_T - 30) @(negedge core_clk);
		check("tx_mode", tx_mode, 16'h0001);
		repeat (40) @(negedge core_clk);
		check("tx_mode", tx_mode, 16'h0000);
		host_model_i.set_dir(1'b1);
		repeat (10) @(negedge core_clk);
		check("tx_mode", tx_mode, 16'h0000);
		// host to modem: clean character, then parity and stop faults
		host_send(8'hFF, 1'b0, 1'b0);
		host_send(8'h5A, 1'b1, 1'b0);
		host_send(8'hC3, 1'b0, 1'b1);
		// modem to host: four back to back, buffer must refuse one
		fork
			begin
				@(negedge core_clk);
				foreach (bytes[i]) push(bytes[i]);
				rx_byte_valid = 1'b0;
			end
			foreach (bytes[i]) begin
				host_model_i.recv_char(got);
				check("serial_in char", got, {1'b1, ~^bytes[i], bytes[i]});
			end
		join
		check("buffer stalled", stalls > 0, 16'h0001);
		// watchdog kept alive, then left silent
		host_model_i.wd_kick();
		repeat (3) begin
			repeat (WD_T - 60) @(negedge core_clk);
			check("reset out", modem_reset_output, 16'h0000);
			host_model_i.wd_kick();
		end
		n0 = host_model_i.nmi_irqs;
		repeat (WD_T + 20) @(negedge core_clk);
		check("reset out", modem_reset_output, 16'h0001);
		check("nmi irqs", 16'(host_model_i.nmi_irqs - n0), 16'h0001);
		check("host restart", host_model_i.host_rst_n, 16'h0000);
		host_model_i.wd_kick();
		repeat (8) @(negedge core_clk);
		check("reset out", modem_reset_output, 16'h0000);
		// low supply asserts reset regardless of the strobe
		supply_low = 1'b1;
		repeat (8) @(negedge core_clk);
		check("reset out", modem_reset_output, 16'h0001);
		supply_low = 1'b0;
		host_model_i.wd_kick();
		repeat (8) @(negedge core_clk);
		check("reset out", modem_reset_output, 16'h0000);
		check("host restart", host_model_i.host_rst_n, 16'h0001);
		// host side housekeeping: keys at rest, heartbeat alive
		check("keys at rest", host_model_i.cmd_keys, 16'h0000);
		hb0 = host_model_i.heartbeat;
		@(negedge core_clk);
		check("heartbeat", host_model_i.heartbeat ^ hb0, 16'h0001);
		tally_and_finish();
	end
endmodule
